// ### design/rpm_compare.sv
/*
 * Per-byte comparison of one received byte against the configured pattern.
 * Assumes pattern, mask and index are stable while a byte is offered.
 */
`timescale 1ns/100ps
`include "rpm_params.svh"

module rpm_compare (
    // configuration
    input  wire logic [511:0] pattern_i,
    input  wire logic [63:0]  mask_i,
    // byte under test
    input  wire logic [5:0]   index_i,
    input  wire logic [7:0]   data_i,
    output logic              hit_o
);
    always_comb begin
        // masked byte always counts as matching
        hit_o = mask_i[index_i] || (pattern_i[{index_i, 3'b000} +: 8] == data_i);
    end
endmodule : rpm_compare

// ### design/rpm_match.sv
/*
 * Receive pattern matcher configuration and comparison, with a Wishbone
 * classic register slave and the receive data bit 3 pin function select.
 * Assumes rx_byte_vld_i/rx_byte_i are on clk_i; the sfd pulse marks the delimiter
 * and rx byte strobe marks each following byte of the frame.
 */
// Register access over Wishbone is this design's own decision.
// Overview of operation
// - Top register holds pattern bytes 63 and 62
// - Four mask registers, sixteen bytes each
// - Start point counts bytes after delimiter
// - Start point resets to twelve
// - Start register upper bits read zero
// - Pin select: data or 50 MHz clock
`timescale 1ns/100ps
`include "rpm_params.svh"

module rpm_match
    import rpm_pkg::*;
(
    // system
    input  wire logic        clk_i,
    input  wire logic        rst_i,
    // wishbone classic slave
    input  wire logic        cyc_i,
    input  wire logic        stb_i,
    input  wire logic        we_i,
    input  wire logic [13:0] adr_i,
    input  wire logic [3:0]  sel_i,
    input  wire logic [31:0] dat_i,
    output logic      [31:0] dat_o,
    output logic             ack_o,
    // received frame stream
    input  wire logic        rx_sfd_i,
    input  wire logic        rx_byte_vld_i,
    input  wire logic [7:0]  rx_byte_i,
    input  wire logic        rx_end_i,
    input  wire logic        rx_data_bit3_i,
    input  wire logic        ref_clk50_i,
    // results
    output logic             match_o,
    output logic             receive_data_bit3_pin_o
);
    logic [15:0]  pattern_top_bytes_reg_ff, nxt_pattern_top_bytes_reg;
    logic [495:0] pat_lo_ff, nxt_pat_lo;
    logic [63:0]  mask_ff, nxt_mask;
    logic [5:0]   pattern_start_ctrl_reg_ff, nxt_pattern_start_ctrl_reg;
    logic [2:0]   bit3_pin_clock_ctrl_reg_ff, nxt_bit3_pin_clock_ctrl_reg;
    logic [8:0]   pat_lo_ptr_ff, nxt_pat_lo_ptr;
    logic [31:0]  dat_ff, nxt_dat;
    logic         ack_ff, nxt_ack;
    rpm_state_t   state_ff, nxt_state;
    logic [6:0]   cnt_ff, nxt_cnt;
    logic         ok_ff, nxt_ok;
    logic         match_ff, nxt_match;
    logic         pin_ff, nxt_pin;
    logic [1:0]   ck_sync_ff, d3_sync_ff;
    logic         hit;
    logic [511:0] pattern_all;
    logic [11:0]  idx;
    logic         wr, rd;

    // merges a 16-bit word into old contents under two byte lanes
    function automatic logic [15:0] merge16(input logic [15:0] old_v,
                                            input logic [15:0] new_v,
                                            input logic [1:0]  be);
        merge16 = {be[1] ? new_v[15:8] : old_v[15:8], be[0] ? new_v[7:0] : old_v[7:0]};
    endfunction : merge16

    assign pattern_all = {pattern_top_bytes_reg_ff, pat_lo_ff};
    assign idx = adr_i[`RPM_ADDR_IDX_MSB:`RPM_ADDR_IDX_LSB];
    assign wr  = cyc_i && stb_i && we_i && !ack_ff;
    assign rd  = cyc_i && stb_i && !we_i && !ack_ff;

    rpm_compare u_cmp (
        .pattern_i (pattern_all),
        .mask_i    (mask_ff),
        .index_i   (cnt_ff[5:0]),
        .data_i    (rx_byte_i),
        .hit_o     (hit)
    );

    // register file; bytes 0..61 are loaded through a word window with auto pointer
    always_comb begin
        nxt_pattern_top_bytes_reg   = pattern_top_bytes_reg_ff;
        nxt_pat_lo                  = pat_lo_ff;
        nxt_mask                    = mask_ff;
        nxt_pattern_start_ctrl_reg  = pattern_start_ctrl_reg_ff;
        nxt_bit3_pin_clock_ctrl_reg = bit3_pin_clock_ctrl_reg_ff;
        nxt_pat_lo_ptr              = pat_lo_ptr_ff;
        nxt_ack                     = cyc_i && stb_i && !ack_ff;
        nxt_dat                     = 32'h0000_0000;
        if (wr) begin
            unique case (idx)
                `RPM_IDX_PAT_TOP: nxt_pattern_top_bytes_reg =
                    merge16(pattern_top_bytes_reg_ff, dat_i[15:0], sel_i[1:0]);
                `RPM_IDX_MASK0: nxt_mask[15:0]  = merge16(mask_ff[15:0], dat_i[15:0], sel_i[1:0]);
                `RPM_IDX_MASK1: nxt_mask[31:16] = merge16(mask_ff[31:16], dat_i[15:0], sel_i[1:0]);
                `RPM_IDX_MASK2: nxt_mask[47:32] = merge16(mask_ff[47:32], dat_i[15:0], sel_i[1:0]);
                `RPM_IDX_MASK3: nxt_mask[63:48] = merge16(mask_ff[63:48], dat_i[15:0], sel_i[1:0]);
                `RPM_IDX_START: if (sel_i[0]) begin
                    nxt_pattern_start_ctrl_reg = dat_i[`RPM_START_MSB:0];
                end
                `RPM_IDX_PIN_CLK: if (sel_i[0]) begin
                    nxt_bit3_pin_clock_ctrl_reg = dat_i[`RPM_PIN_SEL_MSB:0];
                end
                `RPM_IDX_PAT_LO: begin
                    if (pat_lo_ptr_ff > 9'd480) begin
                        nxt_pat_lo_ptr = 9'd0;
                    end else begin
                        nxt_pat_lo[pat_lo_ptr_ff +: 16] =
                            merge16(pat_lo_ff[pat_lo_ptr_ff +: 16], dat_i[15:0], sel_i[1:0]);
                        nxt_pat_lo_ptr = (pat_lo_ptr_ff >= 9'd480) ? 9'd0 : pat_lo_ptr_ff + 9'd16;
                    end
                end
                `RPM_IDX_STATUS: nxt_pat_lo_ptr = 9'd0;
                default: ;
            endcase
        end
        if (rd) begin
            unique case (idx)
                `RPM_IDX_PAT_TOP: nxt_dat[15:0] = pattern_top_bytes_reg_ff;
                `RPM_IDX_MASK0:   nxt_dat[15:0] = mask_ff[15:0];
                `RPM_IDX_MASK1:   nxt_dat[15:0] = mask_ff[31:16];
                `RPM_IDX_MASK2:   nxt_dat[15:0] = mask_ff[47:32];
                `RPM_IDX_MASK3:   nxt_dat[15:0] = mask_ff[63:48];
                `RPM_IDX_START:   nxt_dat[15:0] = {`RPM_RESERVED_ZERO, pattern_start_ctrl_reg_ff};
                `RPM_IDX_PIN_CLK: nxt_dat[15:0] = {13'h0000, bit3_pin_clock_ctrl_reg_ff};
                `RPM_IDX_PAT_LO:  nxt_dat[15:0] =
                    (pat_lo_ptr_ff > 9'd480) ? 16'h0000 : pat_lo_ff[pat_lo_ptr_ff +: 16];
                `RPM_IDX_STATUS:  nxt_dat[15:0] = {5'h00, match_ff, ok_ff, pat_lo_ptr_ff};
                default:          nxt_dat = 32'h0000_0000;
            endcase
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            pattern_top_bytes_reg_ff   <= `RPM_RST_PAT_TOP;
            pat_lo_ff                  <= '0;
            mask_ff                    <= {4{`RPM_RST_MASK}};
            pattern_start_ctrl_reg_ff  <= `RPM_RST_START;
            bit3_pin_clock_ctrl_reg_ff <= `RPM_RST_PIN_SEL;
            pat_lo_ptr_ff              <= 9'd0;
            dat_ff                     <= 32'h0000_0000;
            ack_ff                     <= 1'b0;
        end else begin
            pattern_top_bytes_reg_ff   <= nxt_pattern_top_bytes_reg;
            pat_lo_ff                  <= nxt_pat_lo;
            mask_ff                    <= nxt_mask;
            pattern_start_ctrl_reg_ff  <= nxt_pattern_start_ctrl_reg;
            bit3_pin_clock_ctrl_reg_ff <= nxt_bit3_pin_clock_ctrl_reg;
            pat_lo_ptr_ff              <= nxt_pat_lo_ptr;
            dat_ff                     <= nxt_dat;
            ack_ff                     <= nxt_ack;
        end
    end

    assign dat_o = dat_ff;
    assign ack_o = ack_ff;

    // frame comparison; cnt counts skipped bytes after the delimiter, then compared bytes from 0
    always_comb begin
        nxt_state = state_ff;
        nxt_cnt   = cnt_ff;
        nxt_ok    = ok_ff;
        nxt_match = match_ff;
        if (rx_sfd_i) begin
            nxt_state = (pattern_start_ctrl_reg_ff == 6'h00) ? RPM_CMP : RPM_SKIP;
            nxt_cnt   = 7'd0;
            nxt_ok    = 1'b1;
            nxt_match = 1'b0;
        end else begin
            unique case (state_ff)
                RPM_IDLE: ;
                RPM_SKIP: if (rx_byte_vld_i) begin
                    // byte number cnt is skipped until the start point
                    if (cnt_ff + 7'd1 == {1'b0, pattern_start_ctrl_reg_ff}) begin
                        nxt_state = RPM_CMP;
                        nxt_cnt   = 7'd0;
                    end else begin
                        nxt_cnt = cnt_ff + 7'd1;
                    end
                end
                RPM_CMP: if (rx_byte_vld_i) begin
                    nxt_ok  = ok_ff && hit;
                    nxt_cnt = cnt_ff + 7'd1;
                    if (cnt_ff == 7'd63) begin
                        nxt_state = RPM_DONE;
                        nxt_match = ok_ff && hit;
                    end
                end
                RPM_DONE: ;
            endcase
            if (rx_end_i && state_ff != RPM_DONE) begin
                // frame ended short of the full pattern: no match
                nxt_state = RPM_IDLE;
            end
        end
    end

    // pin mux inputs come from another domain or the pin, so they are synchronised
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            ck_sync_ff <= 2'b00;
            d3_sync_ff <= 2'b00;
        end else begin
            ck_sync_ff <= {ck_sync_ff[0], ref_clk50_i};
            d3_sync_ff <= {d3_sync_ff[0], rx_data_bit3_i};
        end
    end

    always_comb begin
        // a 50 MHz clock cannot be regenerated from a 25 MHz flop; the sampled
        // reference stands in, real silicon would mux the clock tree
        unique case (bit3_pin_clock_ctrl_reg_ff)
            `RPM_PIN_SEL_CLK50: nxt_pin = ck_sync_ff[1];
            default:            nxt_pin = d3_sync_ff[1];
        endcase
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            state_ff <= RPM_IDLE;
            cnt_ff   <= 7'd0;
            ok_ff    <= 1'b0;
            match_ff <= 1'b0;
            pin_ff   <= 1'b0;
        end else begin
            state_ff <= nxt_state;
            cnt_ff   <= nxt_cnt;
            ok_ff    <= nxt_ok;
            match_ff <= nxt_match;
            pin_ff   <= nxt_pin;
        end
    end

    assign match_o                 = match_ff;
    assign receive_data_bit3_pin_o = pin_ff;

    a_ack_one_cycle: assert property (@(posedge clk_i) disable iff (rst_i)
        ack_ff |=> !ack_ff)
        else $error("ack held more than one cycle");
    a_start_reset_val: assert property (@(posedge clk_i)
        $fell(rst_i) |-> pattern_start_ctrl_reg_ff == 6'h0C)
        else $error("start point not twelve after reset");
    a_top_write_read: assert property (@(posedge clk_i) disable iff (rst_i)
        (wr && idx == `RPM_IDX_PAT_TOP && sel_i[1:0] == 2'b11)
        |=> pattern_top_bytes_reg_ff == $past(dat_i[15:0]))
        else $error("pattern top bytes not stored");
    a_start_rsvd_zero: assert property (@(posedge clk_i) disable iff (rst_i)
        $past(rd && idx == `RPM_IDX_START) |-> dat_ff[31:6] == 26'h0)
        else $error("start register reserved bits not zero");
    a_mask_upper_store: assert property (@(posedge clk_i) disable iff (rst_i)
        (wr && idx == `RPM_IDX_MASK3 && sel_i[1:0] == 2'b11)
        |=> mask_ff[63:48] == $past(dat_i[15:0]))
        else $error("mask bytes 48 to 63 not stored");
    a_masked_byte_hit: assert property (@(posedge clk_i) disable iff (rst_i)
        (state_ff == RPM_CMP && mask_ff[cnt_ff[5:0]]) |-> hit)
        else $error("masked byte failed compare");
    a_mismatch_no_match: assert property (@(posedge clk_i) disable iff (rst_i)
        (state_ff == RPM_CMP && rx_byte_vld_i && !hit && !rx_sfd_i) |=> !ok_ff)
        else $error("mismatch did not clear compare result");
    a_skip_to_start: assert property (@(posedge clk_i) disable iff (rst_i)
        (rx_sfd_i && pattern_start_ctrl_reg_ff == 6'h00) |=> state_ff == RPM_CMP)
        else $error("start point zero did not compare first byte");
    a_pin_clock_sel: assert property (@(posedge clk_i) disable iff (rst_i)
        (bit3_pin_clock_ctrl_reg_ff == `RPM_PIN_SEL_CLK50 && $stable(bit3_pin_clock_ctrl_reg_ff))
        |=> receive_data_bit3_pin_o == $past(ck_sync_ff[1]))
        else $error("pin does not carry clock in clock mode");
endmodule : rpm_match

// ### design/rpm_params.svh
/*
 * Register offsets, field positions, reset values and timing counts of the
 * receive pattern matcher configuration slice.
 * Assumes a Wishbone slave with 32-bit words, one register per word.
 */
`ifndef RPM_PARAMS_SVH
`define RPM_PARAMS_SVH

// offsets are register indexes; the byte address is four times the index
`define RPM_IDX_PAT_TOP     12'h4C7
`define RPM_IDX_MASK0       12'h4C8
`define RPM_IDX_MASK1       12'h4C9
`define RPM_IDX_MASK2       12'h4CA
`define RPM_IDX_MASK3       12'h4CB
`define RPM_IDX_START       12'h4CC
`define RPM_IDX_PIN_CLK     12'h4E0
`define RPM_IDX_PAT_LO      12'h4D0
`define RPM_IDX_STATUS      12'h4D1
`define RPM_ADDR_IDX_MSB    13
`define RPM_ADDR_IDX_LSB    2
`define RPM_START_MSB       5
`define RPM_PIN_SEL_MSB     2
`define RPM_RST_PAT_TOP     16'h0000
`define RPM_RST_MASK        16'h0000
`define RPM_RST_START       6'h0C
`define RPM_RST_PIN_SEL     3'h0
`define RPM_PIN_SEL_DATA    3'h0
`define RPM_PIN_SEL_CLK50   3'h3
`define RPM_CLK_HZ          25000000
`define RPM_REF_CLK_HZ      50000000
`define RPM_NUM_BYTES       64
`define RPM_RESERVED_ZERO   10'h000

`endif

// ### design/rpm_pkg.sv
/*
 * Types of the receive pattern matcher.
 * Assumes rpm_params.svh holds all numeric constants.
 */
package rpm_pkg;
    typedef enum logic [1:0] {
        RPM_IDLE,
        RPM_SKIP,
        RPM_CMP,
        RPM_DONE
    } rpm_state_t;
endpackage : rpm_pkg

// ### verification/rpm_frame_src.sv
/*
 * Remote link partner model: sends one received frame at a time into the
 * matcher as delimiter pulse, byte strobes and an end pulse.
 * Assumes it shares the matcher clock and sends one byte per cycle.
 */
`timescale 1ns/100ps

module rpm_frame_src (
    // clock
    input  wire logic       clk_i,
    // frame stream
    output logic            sfd_o,
    output logic            vld_o,
    output logic [7:0]      byte_o,
    output logic            end_o
);
    initial begin
        sfd_o = 1'b0;
        vld_o = 1'b0;
        byte_o = 8'h00;
        end_o = 1'b0;
    end

    // skipped bytes are EE; compared byte k is k except the top two
    task automatic send_frame(input int skip, input logic [7:0] b62, input logic [7:0] b63);
        int k;
        @(posedge clk_i);
        sfd_o <= 1'b1;
        for (int i = 0; i < skip + 64; i++) begin
            @(posedge clk_i);
            k = i - skip;
            sfd_o <= 1'b0;
            vld_o <= 1'b1;
            byte_o <= (i < skip) ? 8'hEE : (k == 62) ? b62 : (k == 63) ? b63 : 8'(k);
        end
        @(posedge clk_i);
        vld_o <= 1'b0;
        end_o <= 1'b1;
        // released data shows the inverse, so a stale byte never looks fresh
        byte_o <= ~byte_o;
        @(posedge clk_i);
        end_o <= 1'b0;
    endtask : send_frame
endmodule : rpm_frame_src

// ### verification/rpm_match_tb_top.sv
/*
 * Self-checking testbench of the receive pattern matcher configuration slice.
 * Assumes rpm_match and rpm_frame_src are compiled before it.
 */
`timescale 1ns/100ps
`include "rpm_params.svh"

module rpm_match_tb_top;
    logic        clk_i = 1'b0;
    logic        rst_i = 1'b1;
    logic        cyc_i = 1'b0;
    logic        stb_i = 1'b0;
    logic        we_i  = 1'b0;
    logic [13:0] adr_i = 14'h0000;
    logic [3:0]  sel_i = 4'h0;
    logic [31:0] dat_i = 32'h0000_0000;
    logic [31:0] dat_o;
    logic        ack_o;
    logic        sfd, vld, fend, match_o, pin;
    logic [7:0]  rx_byte;
    logic        bit3 = 1'b0;
    logic        ref_clk = 1'b0;
    int          n_errors = 0;
    int          tests_run = 0;

    always #20 clk_i = ~clk_i;
    // slightly off 50 MHz so the samples walk through its phase
    always #10.2 ref_clk = ~ref_clk;

    rpm_match u_rpm_match (.clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc_i), .stb_i(stb_i),
        .we_i(we_i), .adr_i(adr_i), .sel_i(sel_i), .dat_i(dat_i), .dat_o(dat_o),
        .ack_o(ack_o), .rx_sfd_i(sfd), .rx_byte_vld_i(vld), .rx_byte_i(rx_byte),
        .rx_end_i(fend), .rx_data_bit3_i(bit3), .ref_clk50_i(ref_clk),
        .match_o(match_o), .receive_data_bit3_pin_o(pin));

    rpm_frame_src u_rpm_frame_src (.clk_i(clk_i), .sfd_o(sfd), .vld_o(vld),
        .byte_o(rx_byte), .end_o(fend));

    task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
        tests_run++;
        if (seen !== exp) begin
            n_errors++;
            $display("unexpected %s: expected %h, seen %h", what, exp, seen);
        end
    endtask : check

    task automatic wb_cycle(input logic [11:0] idx, input logic wr, input logic [15:0] wd,
                            output logic [31:0] rd);
        int n;
        @(posedge clk_i);
        cyc_i <= 1'b1;
        stb_i <= 1'b1;
        we_i <= wr;
        adr_i <= {idx, 2'b00};
        sel_i <= 4'hF;
        dat_i <= {16'h0000, wd};
        do @(posedge clk_i); while (ack_o !== 1'b1);
        rd = dat_o;
        cyc_i <= 1'b0;
        stb_i <= 1'b0;
        we_i <= 1'b0;
    endtask : wb_cycle

    task automatic wr(input logic [11:0] idx, input logic [15:0] d);
        logic [31:0] unused;
        wb_cycle(idx, 1'b1, d, unused);
    endtask : wr

    task automatic rd_chk(input string what, input logic [11:0] idx, input logic [15:0] exp);
        logic [31:0] v;
        wb_cycle(idx, 1'b0, 16'h0000, v);
        check(what, v, {16'h0000, exp});
    endtask : rd_chk

    task automatic frame_chk(input string what, input int skip, input logic [7:0] b63,
                             input logic exp);
        u_rpm_frame_src.send_frame(skip, 8'h5A, b63);
        repeat (2) @(posedge clk_i);
        check(what, {31'h0, match_o}, {31'h0, exp});
    endtask : frame_chk

    task automatic t_reset_vals();
        rd_chk("top pattern reset", `RPM_IDX_PAT_TOP, 16'h0000);
        rd_chk("mask0 reset", `RPM_IDX_MASK0, 16'h0000);
        rd_chk("mask2 reset", `RPM_IDX_MASK2, 16'h0000);
        rd_chk("start reset", `RPM_IDX_START, 16'h000C);
        rd_chk("pin select reset", `RPM_IDX_PIN_CLK, 16'h0000);
    endtask : t_reset_vals

    task automatic t_reg_access();
        wr(`RPM_IDX_PAT_TOP, 16'hA55A);
        rd_chk("top pattern", `RPM_IDX_PAT_TOP, 16'hA55A);
        wr(`RPM_IDX_START, 16'hFFFF);
        rd_chk("start reserved bits", `RPM_IDX_START, 16'h003F);
        wr(`RPM_IDX_START, 16'h000C);
        wr(12'h4E1, 16'h1234);
        rd_chk("unmapped read", 12'h4E1, 16'h0000);
        // only bytes 62 and 63 stay in the compare
        for (int m = 0; m < 3; m++) begin
            wr(12'(`RPM_IDX_MASK0 + m), 16'hFFFF);
        end
        wr(`RPM_IDX_MASK3, 16'h3FFF);
        rd_chk("mask1", `RPM_IDX_MASK1, 16'hFFFF);
        rd_chk("mask3", `RPM_IDX_MASK3, 16'h3FFF);
    endtask : t_reg_access

    task automatic t_match();
        frame_chk("match at default start", 12, 8'hA5, 1'b1);
        wr(`RPM_IDX_START, 16'h0000);
        frame_chk("match from first byte", 0, 8'hA5, 1'b1);
        frame_chk("byte 63 differs", 0, 8'h00, 1'b0);
        wr(`RPM_IDX_MASK3, 16'hBFFF);
        frame_chk("byte 63 masked", 0, 8'h00, 1'b1);
        wr(`RPM_IDX_MASK3, 16'h3FFF);
        wr(`RPM_IDX_START, 16'h0001);
        frame_chk("match from second byte", 1, 8'hA5, 1'b1);
        wr(`RPM_IDX_START, 16'h0000);
        frame_chk("shifted frame", 1, 8'hA5, 1'b0);
    endtask : t_match

    // low pattern window, unmasked low bytes and the lower half of the top register;
    // runs after t_match, so the last frame left match and running ok both low
    task automatic t_window();
        wr(`RPM_IDX_PAT_LO, 16'h0100);
        rd_chk("window pointer", `RPM_IDX_STATUS, 16'h0010);
        wr(`RPM_IDX_STATUS, 16'h0000);
        rd_chk("window word 0", `RPM_IDX_PAT_LO, 16'h0100);
        wr(`RPM_IDX_MASK0, 16'hFFFC);
        frame_chk("bytes 0 and 1 compared", 0, 8'hA5, 1'b1);
        wr(`RPM_IDX_STATUS, 16'h0000);
        wr(`RPM_IDX_PAT_LO, 16'h0200);
        frame_chk("byte 1 differs", 0, 8'hA5, 1'b0);
        wr(`RPM_IDX_MASK0, 16'hFFFF);
        wr(`RPM_IDX_PAT_TOP, 16'hA55B);
        frame_chk("byte 62 differs", 0, 8'hA5, 1'b0);
    endtask : t_window

    task automatic t_pin();
        int   cnt;
        logic prev;
        bit3 <= 1'b1;
        repeat (4) @(posedge clk_i);
        check("pin follows data high", {31'h0, pin}, 32'h1);
        bit3 <= 1'b0;
        repeat (4) @(posedge clk_i);
        check("pin follows data low", {31'h0, pin}, 32'h0);
        wr(`RPM_IDX_PIN_CLK, 16'h0003);
        rd_chk("pin select", `RPM_IDX_PIN_CLK, 16'h0003);
        cnt = 0;
        prev = pin;
        repeat (200) begin
            @(posedge clk_i);
            if (pin !== prev) begin
                cnt++;
            end
            prev = pin;
        end
        check("clock on pin", {31'h0, cnt > 2}, 32'h1);
    endtask : t_pin

    task automatic results();
        $display("checks %0d, mismatches %0d", tests_run, n_errors);
        if (n_errors == 0 && tests_run > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask : results

    initial begin
        #400000;
        n_errors++;
        results();
    end

    initial begin
        repeat (3) @(posedge clk_i);
        rst_i <= 1'b0;
        t_reset_vals();
        t_reg_access();
        t_match();
        t_window();
        t_pin();
        results();
    end
endmodule : rpm_match_tb_top
